// [src/pps_pkg.sv]
// constants and types for the port power source select bank
package pps_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_PORTS = 3;
  // register byte addresses, ports 3, 4 and 5
  localparam logic [ADDR_W-1:0] PORT3_SEL_ADDR = 16'h3c08;
  localparam logic [ADDR_W-1:0] PORT4_SEL_ADDR = 16'h3c0c;
  localparam logic [ADDR_W-1:0] PORT5_SEL_ADDR = 16'h3c10;
  // field positions
  localparam int SHARED_PIN_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int DISABLE_BIT = 5;
  localparam int FIXED_DEV_BIT = 4;
  localparam int SRC_MSB = 3;
  localparam int SRC_LSB = 0;
  // reset value of each select register
  localparam logic [DATA_W-1:0] SEL_RESET = 8'h00;
  // mask of the writable bits
  localparam logic [DATA_W-1:0] SEL_WR_MASK = 8'hbf;
  // answer for an unmapped read
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;
  // power source codes
  typedef enum logic [3:0] {
    PPS_SRC_OFF = 4'h0,
    PPS_SRC_HUB2 = 4'h1,
    PPS_SRC_HUB3 = 4'h2,
    PPS_SRC_EITHER = 4'h3,
    PPS_SRC_GPIO = 4'h4
  } pps_src_t;
endpackage

// [src/pps_port_power_select.sv]
// register bank selecting the power source of downstream ports 3, 4, 5
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Function
// R1 - one select register per port, 0x3c08-0x3c10
// R2 - bit 7 set: power and sense share pin
// R3 - bit 5 set: port permanently disabled
// R4 - bit 4 set: permanently attached device
// R5 - source 0000b keeps port power off
// R6 - source 0001b follows hub2 power state
// R7 - source 0010b follows hub3 power state
// R8 - source 0011b follows either power state
// R9 - source 0100b follows designated gpio pin
// R10 - software writes only defined source codes
// R11 - configurer loads bits before hub enumerates
// R12 - settings not changed while hub operates
// R13 - bit 6 reads zero, ignores writes
module pps_port_power_select (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [pps_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pps_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pps_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [pps_pkg::NUM_PORTS-1:0] HUB2_PWR_I,
  input wire logic [pps_pkg::NUM_PORTS-1:0] HUB3_PWR_I,
  input wire logic [pps_pkg::NUM_PORTS-1:0] GPIO_PWR_I,
  output logic [pps_pkg::NUM_PORTS-1:0] PORT_PWR_O,
  output logic [pps_pkg::NUM_PORTS-1:0] SHARED_PIN_O,
  output logic [pps_pkg::NUM_PORTS-1:0] PORT_DISABLED_O,
  output logic [pps_pkg::NUM_PORTS-1:0] FIXED_ATTACHED_DEVICE_O
);
  import pps_pkg::*;

  logic [DATA_W-1:0] sel_ff [NUM_PORTS];
  logic [DATA_W-1:0] nxt_rdata;
  logic [NUM_PORTS-1:0] hit;
  logic [NUM_PORTS-1:0] nxt_pwr;
  // power state inputs come from other domains: two-stage synchronisers
  logic [NUM_PORTS-1:0] hub2_meta_ff, hub2_ff;
  logic [NUM_PORTS-1:0] hub3_meta_ff, hub3_ff;
  logic [NUM_PORTS-1:0] gpio_meta_ff, gpio_ff;

  // R1 address decode
  assign hit[0] = (ADDR_I == PORT3_SEL_ADDR);
  assign hit[1] = (ADDR_I == PORT4_SEL_ADDR);
  assign hit[2] = (ADDR_I == PORT5_SEL_ADDR);

  // synchronise the pin and hub inputs
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hub2_meta_ff <= '0;
      hub2_ff <= '0;
      hub3_meta_ff <= '0;
      hub3_ff <= '0;
      gpio_meta_ff <= '0;
      gpio_ff <= '0;
    end else begin
      hub2_meta_ff <= HUB2_PWR_I;
      hub2_ff <= hub2_meta_ff;
      hub3_meta_ff <= HUB3_PWR_I;
      hub3_ff <= hub3_meta_ff;
      gpio_meta_ff <= GPIO_PWR_I;
      gpio_ff <= gpio_meta_ff;
    end
  end

  // R13 register writes, reserved bit masked off
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        sel_ff[i] <= SEL_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (WR_I && hit[i]) begin
          sel_ff[i] <= WDATA_I & SEL_WR_MASK;
        end
      end
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    nxt_rdata = UNMAPPED_DATA;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (hit[i]) begin
        nxt_rdata = sel_ff[i];
      end
    end
  end

  // read data valid one cycle after the strobe only
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      RDATA_O <= nxt_rdata;
    end else begin
      RDATA_O <= '0;
    end
  end

  // power source selection per port
  always_comb begin
    nxt_pwr = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      case (pps_src_t'(sel_ff[i][SRC_MSB:SRC_LSB]))
        // R5 source off
        PPS_SRC_OFF: nxt_pwr[i] = 1'b0;
        // R6 follow hub2
        PPS_SRC_HUB2: nxt_pwr[i] = hub2_ff[i];
        // R7 follow hub3
        PPS_SRC_HUB3: nxt_pwr[i] = hub3_ff[i];
        // R8 either state
        PPS_SRC_EITHER: nxt_pwr[i] = hub2_ff[i] | hub3_ff[i];
        // R9 follow gpio
        PPS_SRC_GPIO: nxt_pwr[i] = gpio_ff[i];
        // R10 reserved codes keep power off
        default: nxt_pwr[i] = 1'b0;
      endcase
    end
  end

  // registered port outputs
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PORT_PWR_O <= '0;
      SHARED_PIN_O <= '0;
      PORT_DISABLED_O <= '0;
      FIXED_ATTACHED_DEVICE_O <= '0;
    end else begin
      PORT_PWR_O <= nxt_pwr;
      for (int i = 0; i < NUM_PORTS; i++) begin
        // R2 shared pin flag
        SHARED_PIN_O[i] <= sel_ff[i][SHARED_PIN_BIT];
        // R3 disable flag
        PORT_DISABLED_O[i] <= sel_ff[i][DISABLE_BIT];
        // R4 fixed device flag
        FIXED_ATTACHED_DEVICE_O[i] <= sel_ff[i][FIXED_DEV_BIT];
      end
    end
  end

  // assertions, rules R1 to R9 and R13 checked on every port
  // R13 reserved bit reads zero
  AST_RSVD_ZERO: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R13
    RD_I |=> RDATA_O[RSVD_BIT] == 1'b0) else $error("reserved bit read nonzero");

  // R1 port3 write then read back
  AST_WR_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (WR_I && ADDR_I == PORT3_SEL_ADDR) ##1 (RD_I && ADDR_I == PORT3_SEL_ADDR && !WR_I)
    |=> RDATA_O == ($past(WDATA_I, 2) & SEL_WR_MASK)) else $error("port3 readback wrong");

  // R1 port4 write then read back
  AST_WR_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (WR_I && ADDR_I == PORT4_SEL_ADDR) ##1 (RD_I && ADDR_I == PORT4_SEL_ADDR && !WR_I)
    |=> RDATA_O == ($past(WDATA_I, 2) & SEL_WR_MASK)) else $error("port4 readback wrong");

  // R1 port5 write then read back
  AST_WR_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (WR_I && ADDR_I == PORT5_SEL_ADDR) ##1 (RD_I && ADDR_I == PORT5_SEL_ADDR && !WR_I)
    |=> RDATA_O == ($past(WDATA_I, 2) & SEL_WR_MASK)) else $error("port5 readback wrong");

  // R1 port3 read returns register
  AST_RD_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (RD_I && hit[0]) |=> RDATA_O == $past(sel_ff[0])) else $error("port3 read wrong");

  // R1 port4 read returns register
  AST_RD_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (RD_I && hit[1]) |=> RDATA_O == $past(sel_ff[1])) else $error("port4 read wrong");

  // R1 port5 read returns register
  AST_RD_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (RD_I && hit[2]) |=> RDATA_O == $past(sel_ff[2])) else $error("port5 read wrong");

  // R1 unmapped read answers zero
  AST_UNMAPPED: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    (RD_I && !(|hit)) |=> RDATA_O == UNMAPPED_DATA) else $error("unmapped read nonzero");

  // R1 read data only after strobe
  AST_RD_IDLE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    !RD_I |=> RDATA_O == '0) else $error("read data stands too long");

  // R1 port3 held without write
  AST_HOLD_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    !(WR_I && hit[0]) |=> $stable(sel_ff[0])) else $error("port3 changed unwritten");

  // R1 port4 held without write
  AST_HOLD_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    !(WR_I && hit[1]) |=> $stable(sel_ff[1])) else $error("port4 changed unwritten");

  // R1 port5 held without write
  AST_HOLD_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    !(WR_I && hit[2]) |=> $stable(sel_ff[2])) else $error("port5 changed unwritten");

  // R13 reserved bit never stored
  AST_RSVD_STORE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R13
    !(sel_ff[0][RSVD_BIT] | sel_ff[1][RSVD_BIT] | sel_ff[2][RSVD_BIT]))
    else $error("reserved bit stored");

  // R5 port3 power off
  AST_OFF: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R5
    (sel_ff[0][SRC_MSB:SRC_LSB] == PPS_SRC_OFF) |=> !PORT_PWR_O[0]) else $error("power on");

  // R5 port4 power off
  AST_OFF_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R5
    (sel_ff[1][SRC_MSB:SRC_LSB] == PPS_SRC_OFF) |=> !PORT_PWR_O[1]) else $error("port4 on");

  // R5 port5 power off
  AST_OFF_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R5
    (sel_ff[2][SRC_MSB:SRC_LSB] == PPS_SRC_OFF) |=> !PORT_PWR_O[2]) else $error("port5 on");

  // R6 port4 follows hub2
  AST_HUB2: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
    (sel_ff[1][SRC_MSB:SRC_LSB] == PPS_SRC_HUB2) |=> PORT_PWR_O[1] == $past(hub2_ff[1]))
    else $error("hub2 follow wrong");

  // R6 port3 follows hub2
  AST_HUB2_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
    (sel_ff[0][SRC_MSB:SRC_LSB] == PPS_SRC_HUB2) |=> PORT_PWR_O[0] == $past(hub2_ff[0]))
    else $error("port3 hub2 follow wrong");

  // R6 port5 follows hub2
  AST_HUB2_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
    (sel_ff[2][SRC_MSB:SRC_LSB] == PPS_SRC_HUB2) |=> PORT_PWR_O[2] == $past(hub2_ff[2]))
    else $error("port5 hub2 follow wrong");

  // R7 port5 follows hub3
  AST_HUB3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R7
    (sel_ff[2][SRC_MSB:SRC_LSB] == PPS_SRC_HUB3) |=> PORT_PWR_O[2] == $past(hub3_ff[2]))
    else $error("hub3 follow wrong");

  // R7 port3 follows hub3
  AST_HUB3_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R7
    (sel_ff[0][SRC_MSB:SRC_LSB] == PPS_SRC_HUB3) |=> PORT_PWR_O[0] == $past(hub3_ff[0]))
    else $error("port3 hub3 follow wrong");

  // R7 port4 follows hub3
  AST_HUB3_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R7
    (sel_ff[1][SRC_MSB:SRC_LSB] == PPS_SRC_HUB3) |=> PORT_PWR_O[1] == $past(hub3_ff[1]))
    else $error("port4 hub3 follow wrong");

  // R8 port3 either state
  AST_EITHER: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R8
    (sel_ff[0][SRC_MSB:SRC_LSB] == PPS_SRC_EITHER)
    |=> PORT_PWR_O[0] == ($past(hub2_ff[0]) | $past(hub3_ff[0]))) else $error("or wrong");

  // R8 port4 either state
  AST_EITHER_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R8
    (sel_ff[1][SRC_MSB:SRC_LSB] == PPS_SRC_EITHER)
    |=> PORT_PWR_O[1] == ($past(hub2_ff[1]) | $past(hub3_ff[1]))) else $error("port4 or");

  // R8 port5 either state
  AST_EITHER_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R8
    (sel_ff[2][SRC_MSB:SRC_LSB] == PPS_SRC_EITHER)
    |=> PORT_PWR_O[2] == ($past(hub2_ff[2]) | $past(hub3_ff[2]))) else $error("port5 or");

  // R9 port4 follows gpio
  AST_GPIO: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
    (sel_ff[1][SRC_MSB:SRC_LSB] == PPS_SRC_GPIO) |=> PORT_PWR_O[1] == $past(gpio_ff[1]))
    else $error("gpio follow wrong");

  // R9 port3 follows gpio
  AST_GPIO_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
    (sel_ff[0][SRC_MSB:SRC_LSB] == PPS_SRC_GPIO) |=> PORT_PWR_O[0] == $past(gpio_ff[0]))
    else $error("port3 gpio follow wrong");

  // R9 port5 follows gpio
  AST_GPIO_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
    (sel_ff[2][SRC_MSB:SRC_LSB] == PPS_SRC_GPIO) |=> PORT_PWR_O[2] == $past(gpio_ff[2]))
    else $error("port5 gpio follow wrong");

  // R2 port5 shared flag
  AST_FLAGS: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R2
    ##1 SHARED_PIN_O[2] == $past(sel_ff[2][SHARED_PIN_BIT])) else $error("shared flag");

  // R2 port3 shared flag
  AST_SHARED_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R2
    ##1 SHARED_PIN_O[0] == $past(sel_ff[0][SHARED_PIN_BIT])) else $error("port3 shared");

  // R2 port4 shared flag
  AST_SHARED_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R2
    ##1 SHARED_PIN_O[1] == $past(sel_ff[1][SHARED_PIN_BIT])) else $error("port4 shared");

  // R3 port3 disable flag
  AST_DIS: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
    ##1 PORT_DISABLED_O[0] == $past(sel_ff[0][DISABLE_BIT])) else $error("disable flag");

  // R3 port4 disable flag
  AST_DIS_P4: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
    ##1 PORT_DISABLED_O[1] == $past(sel_ff[1][DISABLE_BIT])) else $error("port4 disable");

  // R3 port5 disable flag
  AST_DIS_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
    ##1 PORT_DISABLED_O[2] == $past(sel_ff[2][DISABLE_BIT])) else $error("port5 disable");

  // R4 port4 fixed device
  AST_FIX: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R4
    ##1 FIXED_ATTACHED_DEVICE_O[1] == $past(sel_ff[1][FIXED_DEV_BIT]))
    else $error("fixed device flag");

  // R4 port3 fixed device
  AST_FIX_P3: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R4
    ##1 FIXED_ATTACHED_DEVICE_O[0] == $past(sel_ff[0][FIXED_DEV_BIT]))
    else $error("port3 fixed device flag");

  // R4 port5 fixed device
  AST_FIX_P5: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R4
    ##1 FIXED_ATTACHED_DEVICE_O[2] == $past(sel_ff[2][FIXED_DEV_BIT]))
    else $error("port5 fixed device flag");

endmodule

// [verification/tb_top.sv]
// self-checking bench for the port power source select bank
`timescale 1ns/1ps
module tb_top;
  import pps_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [2:0] h2 = '0, h3 = '0, gp = '0;
  wire [DATA_W-1:0] rdata;
  wire [2:0] pwr, shp, dis, fix;
  int err_total = 0, tests_run = 0;
  logic [ADDR_W-1:0] adr [3] = '{PORT3_SEL_ADDR, PORT4_SEL_ADDR, PORT5_SEL_ADDR};
  // clock, 10 ns period
  always #5 clk = ~clk;
  pps_port_power_select u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HUB2_PWR_I(h2),
    .HUB3_PWR_I(h3), .GPIO_PWR_I(gp), .PORT_PWR_O(pwr), .SHARED_PIN_O(shp),
    .PORT_DISABLED_O(dis), .FIXED_ATTACHED_DEVICE_O(fix));
  // compare and count
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle bus write
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle bus read, data judged in the following cycle
  task automatic rd_reg(string nm, logic [15:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask
  // expected power enable for a source code
  function automatic logic pexp(int c, logic a, logic b, logic g);
    case (c)
      1: return a;
      2: return b;
      3: return a | b;
      4: return g;
      default: return 1'b0;
    endcase
  endfunction
  // reset values, flag mapping, reserved bit, unmapped place
  task automatic t_regs();
    for (int i = 0; i < 3; i++) rd_reg("reset", adr[i], SEL_RESET);
    wr_reg(adr[0], 8'h80);
    wr_reg(adr[1], 8'h20);
    wr_reg(adr[2], 8'h10);
    repeat (3) @(posedge clk);
    #1 chk("shared", {5'h0, shp}, 8'h01);
    chk("disabled", {5'h0, dis}, 8'h02);
    chk("fixed", {5'h0, fix}, 8'h04);
    // reserved bit set, defined source code only
    for (int i = 0; i < 3; i++) wr_reg(adr[i], 8'hf4);
    for (int i = 0; i < 3; i++) rd_reg("rsvd", adr[i], 8'hb4);
    wr_reg(16'h3c09, 8'h00);
    rd_reg("unmapped", 16'h3c09, UNMAPPED_DATA);
    rd_reg("intact", adr[0], 8'hb4);
    repeat (3) @(posedge clk);
    #1 chk("allshared", {5'h0, shp}, 8'h07);
    chk("alldisabled", {5'h0, dis}, 8'h07);
    chk("allfixed", {5'h0, fix}, 8'h07);
    $display("test regs done");
  endtask
  // every defined source code (0 to 4) against every input pattern
  task automatic t_src();
    // only the defined source codes are written
    for (int c = 0; c < 5; c++) begin
      // set up before the power inputs move
      for (int i = 0; i < 3; i++) wr_reg(adr[i], 8'(c));
      for (int p = 0; p < 8; p++) begin
        @(posedge clk);
        h2 <= {3{p[0]}};
        h3 <= {3{p[1]}};
        gp <= {3{p[2]}};
        repeat (5) @(posedge clk);
        #1 chk("power", {5'h0, pwr}, {5'h0, {3{pexp(c, p[0], p[1], p[2])}}});
      end
    end
    $display("test sources done");
  endtask
  // write then read of the same register with no gap
  task automatic t_b2b();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= adr[i];
      wdata <= 8'h90 | 8'(i + 2);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("b2b", rdata, 8'h90 | 8'(i + 2));
      @(posedge clk);
      #1 chk("rdidle", rdata, 8'h00);
    end
    $display("test back to back done");
  endtask
  // reset in mid-run clears registers and outputs
  task automatic t_reset();
    // flags and gpio source set up front
    for (int i = 0; i < 3; i++) wr_reg(adr[i], 8'hb4);
    repeat (3) @(posedge clk);
    #1 chk("prerst", {5'h0, pwr}, 8'h07);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("rstpwr", {5'h0, pwr}, 8'h00);
    chk("rstflags", {2'h0, shp, dis}, 8'h00);
    chk("rstfix", {5'h0, fix}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd_reg("rstval", adr[i], SEL_RESET);
    repeat (3) @(posedge clk);
    #1 chk("offpwr", {5'h0, pwr}, 8'h00);
    $display("test reset done");
  endtask
  // counts and verdict, ends the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_b2b();
    t_src();
    t_reset();
    print_verdict();
  end
  // hang guard, several times the expected run length
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule
